/* File: logic/smq_monitor.sv */
`timescale 1ns/1ps
// Summary of operation
// [RULE1] monitor mode detected at power-up, then fixed
// [RULE2] four undervoltage levels and one overvoltage level
// [RULE3] undervoltage reported after persisting qualification time
// [RULE4] undervoltage clearance reported after same time
// [RULE5] recovery reports shallower remaining undervoltage level
// [RULE6] qualified overvoltage ends on-time, reports fault
// [RULE7] turn-on ignored until overvoltage released with hysteresis
// [RULE8] overvoltage clearance issues a status update
// [RULE9] thermal fault reported after thermal delay expires
// [RULE10] undervoltage works with overvoltage defeated
// [RULE11] status line only pulled low or released
// [RULE12] host should withhold other turn-ons during overvoltage
// [RULE13] host should repeat power-up after overvoltage
// [RULE14] fault codes in bits 0..2, clearances reported
// [RULE15] inputs synchronised, lapse restarts timer silently
// [RULE16] one status event per qualified change; changes in the same cycle share one event
module smq_monitor #(
  parameter int UV_TICKS = smq_pkg::UV_QUAL_TICKS,
  parameter int OV_TICKS = smq_pkg::OV_QUAL_TICKS,
  parameter int THERM_TICKS = smq_pkg::THERM_DELAY_TICKS
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [smq_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // comparators behind the system monitor pin
  input wire logic mode_sense_i,
  input wire logic ov_above_cmp_i,
  input wire logic ov_release_cmp_i,
  input wire logic [3:0] uv_below_cmp_i,
  input wire logic thermal_below_cmp_i,
  // gate control
  input wire logic low_side_gate_request_i,
  input wire logic high_side_gate_request_n_i,
  output logic low_side_drive_o,
  output logic high_side_drive_o,
  // status communication logic and open-drain status line
  input wire logic status_pull_req_i,
  input wire logic status_line_i,
  output logic status_line_o,
  output logic status_line_oe_o,
  output logic status_event_o,
  output logic [2:0] status_code_o
);

  // --------------------------------------------------------------------------
  // input synchronisers and tick divider
  // --------------------------------------------------------------------------
  localparam int SYNC_W = 8;

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [smq_pkg::TICK_DIV_W-1:0] div_q;
  logic tick_q;

  if (smq_pkg::TICK_CYCLES < 2 || smq_pkg::TICK_CYCLES >= 2 ** smq_pkg::TICK_DIV_W)
  begin : g_bad_tick
    $error("smq_monitor: tick divider does not fit");
  end

  // first stage feeds only the second (see [RULE15]); no reset, so the
  // strap has reached the second stage by the time reset lifts
  always_ff @(posedge mclk_i)
  begin
    sync1_q <= {mode_sense_i, thermal_below_cmp_i, uv_below_cmp_i,
                ov_release_cmp_i, ov_above_cmp_i};
    sync2_q <= sync1_q;
  end

  // one-cycle enable every microsecond keeps the timers narrow
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == smq_pkg::TICK_DIV_W'(smq_pkg::TICK_CYCLES - 1));
      div_q <= (div_q == smq_pkg::TICK_DIV_W'(smq_pkg::TICK_CYCLES - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // mode lock-in
  // --------------------------------------------------------------------------
  logic mode_locked_q;
  logic thermal_mode_q;
  logic bus_mode;
  logic therm_mode;

  // strap taken at the first edge after release, then held until the
  // next reset (see [RULE1])
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      mode_locked_q <= 1'b0;
      thermal_mode_q <= 1'b0;
    end
    else if (!mode_locked_q)
    begin
      mode_locked_q <= 1'b1;
      thermal_mode_q <= sync2_q[7];
    end
  end

  assign bus_mode = mode_locked_q && !thermal_mode_q;
  assign therm_mode = mode_locked_q && thermal_mode_q;

  // --------------------------------------------------------------------------
  // condition qualifiers
  // --------------------------------------------------------------------------
  smq_qual_if q_if[smq_pkg::NUM_COND] ();
  logic [smq_pkg::NUM_COND-1:0] act;
  logic [smq_pkg::NUM_COND-1:0] chg;

  for (genvar g = 0; g < smq_pkg::NUM_COND; g++)
  begin : g_cond
    localparam int LIM = (g == smq_pkg::IDX_OV) ? OV_TICKS :
                         (g == smq_pkg::IDX_THERM) ? THERM_TICKS : UV_TICKS;
    if (g == smq_pkg::IDX_OV)
    begin : g_ov
      // release needs the lower hysteresis comparator (see [RULE7])
      assign q_if[g].set_cond = bus_mode && sync2_q[0]; // see [RULE2]
      assign q_if[g].clr_cond = !bus_mode || sync2_q[1];
    end
    else if (g == smq_pkg::IDX_THERM)
    begin : g_th
      assign q_if[g].set_cond = therm_mode && sync2_q[6]; // see [RULE9]
      assign q_if[g].clr_cond = !(therm_mode && sync2_q[6]);
    end
    else
    begin : g_uv
      // own comparator, so a defeated overvoltage path changes nothing here
      assign q_if[g].set_cond = bus_mode && sync2_q[g + 1]; // see [RULE10]
      assign q_if[g].clr_cond = !(bus_mode && sync2_q[g + 1]); // see [RULE4]
    end
    assign act[g] = q_if[g].active;
    assign chg[g] = q_if[g].changed;

    smq_qualifier #(
      .LIMIT(LIM)
    ) u_qual (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .tick_i(tick_q),
      .qif(q_if[g])
    );
  end

  // --------------------------------------------------------------------------
  // fault code and status event
  // --------------------------------------------------------------------------
  logic [2:0] code_d;
  logic report_en_q;
  logic status_event_q;
  logic [2:0] status_code_q;
  logic [smq_pkg::EVCNT_W-1:0] evcnt_q;

  // overvoltage first, then the deepest undervoltage still present, so a
  // partial recovery lands on the shallower level (see [RULE5])
  always_comb
  begin
    code_d = smq_pkg::CODE_NONE;
    if (act[smq_pkg::IDX_OV])
      code_d = smq_pkg::CODE_OV; // see [RULE14]
    else if (act[smq_pkg::IDX_UV_55])
      code_d = smq_pkg::CODE_UV_55;
    else if (act[smq_pkg::IDX_UV_70])
      code_d = smq_pkg::CODE_UV_70;
    else if (act[smq_pkg::IDX_UV_85])
      code_d = smq_pkg::CODE_UV_85;
    else if (act[smq_pkg::IDX_UV_FULL])
      code_d = smq_pkg::CODE_UV_FULL;
    else if (act[smq_pkg::IDX_THERM])
      code_d = smq_pkg::CODE_THERM;
  end

  // any cycle with flips, set or clear, gives exactly one event while report enable is set (see [RULE16])
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      status_event_q <= 1'b0;
      status_code_q <= smq_pkg::CODE_NONE;
      evcnt_q <= '0;
    end
    else
    begin
      status_code_q <= code_d;
      status_event_q <= (|chg) && report_en_q; // see [RULE3] [RULE8]
      if ((|chg) && report_en_q)
        evcnt_q <= evcnt_q + 1'b1;
    end
  end

  assign status_event_o = status_event_q;
  assign status_code_o = status_code_q;

  // the line is only ever pulled low or let go (see [RULE11])
  assign status_line_o = 1'b0;
  assign status_line_oe_o = status_pull_req_i;

  // --------------------------------------------------------------------------
  // gate inhibit
  // --------------------------------------------------------------------------
  logic ls_block_q;
  logic hs_block_q;
  logic ls_drive_q;
  logic hs_drive_q;
  logic ov_act;

  assign ov_act = act[smq_pkg::IDX_OV];

  // a request still held across the fault needs a fresh turn-on edge, so
  // the block stays until the request is withdrawn (see [RULE7])
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ls_block_q <= 1'b0;
      hs_block_q <= 1'b0;
    end
    else
    begin
      ls_block_q <= ov_act || (ls_block_q && low_side_gate_request_i);
      hs_block_q <= ov_act || (hs_block_q && !high_side_gate_request_n_i);
    end
  end

  // qualified overvoltage cuts both on-times at once (see [RULE6])
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ls_drive_q <= 1'b0;
      hs_drive_q <= 1'b0;
    end
    else
    begin
      ls_drive_q <= low_side_gate_request_i && !ov_act && !ls_block_q;
      hs_drive_q <= !high_side_gate_request_n_i && !ov_act && !hs_block_q;
    end
  end

  assign low_side_drive_o = ls_drive_q;
  assign high_side_drive_o = hs_drive_q;

  // --------------------------------------------------------------------------
  // apb registers
  // --------------------------------------------------------------------------
  logic [31:0] prdata_q;
  logic mapped;
  logic [31:0] status_word;

  assign mapped = (paddr_i == smq_pkg::REG_CTRL) || (paddr_i == smq_pkg::REG_STATUS)
                  || (paddr_i == smq_pkg::REG_EVCNT);

  always_comb
  begin
    status_word = '0;
    status_word[smq_pkg::ST_CODE_LSB +: 3] = status_code_q;
    status_word[smq_pkg::ST_MODE_BIT] = thermal_mode_q;
    status_word[smq_pkg::ST_INHIBIT_BIT] = ov_act;
    status_word[smq_pkg::ST_LINE_BIT] = status_line_i;
    status_word[smq_pkg::ST_ACTIVE_LSB +: smq_pkg::NUM_COND] = act;
  end

  // report enable steers whether qualified changes leave as events
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      report_en_q <= smq_pkg::CTRL_RESET_VAL;
    else if (psel_i && penable_i && pwrite_i && paddr_i == smq_pkg::REG_CTRL)
      report_en_q <= pwdata_i[smq_pkg::CTRL_REPORT_EN_BIT];
  end

  // read data registered in the setup cycle, stable through the access
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      prdata_q <= '0;
    else if (psel_i && !penable_i)
    begin
      prdata_q <= '0;
      if (paddr_i == smq_pkg::REG_CTRL)
        prdata_q[smq_pkg::CTRL_REPORT_EN_BIT] <= report_en_q;
      else if (paddr_i == smq_pkg::REG_STATUS)
        prdata_q <= status_word;
      else if (paddr_i == smq_pkg::REG_EVCNT)
        prdata_q[smq_pkg::EVCNT_W-1:0] <= evcnt_q;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_mode_held: assert property (mode_locked_q |=> mode_locked_q && $stable(thermal_mode_q)) // see [RULE1]
    else $error("monitor mode changed after lock");
  a_ov_code: assert property (ov_act |=> status_code_q == smq_pkg::CODE_OV) // see [RULE14]
    else $error("overvoltage not coded first");
  a_uv_shallow: assert property (act[2:1] == 2'b11 && act[4:3] == 2'b00 && !ov_act // see [RULE5]
    |=> status_code_q == smq_pkg::CODE_UV_85)
    else $error("remaining undervoltage level not reported");
  a_ov_cut: assert property (ov_act |=> !low_side_drive_o && !high_side_drive_o) // see [RULE6]
    else $error("gate driven during overvoltage");
  a_ov_block: assert property ($fell(ov_act) && low_side_gate_request_i // see [RULE7]
    |=> !low_side_drive_o)
    else $error("held turn-on passed after overvoltage");
  a_event_cause: assert property (status_event_o |-> $past(|chg) && $past(report_en_q)) // see [RULE16]
    else $error("status event without qualified change");
  a_ov_clear_ev: assert property ($fell(ov_act) && report_en_q |-> ##1 status_event_o) // see [RULE8]
    else $error("overvoltage clearance not reported");
  a_line_low: assert property (!status_line_o) // see [RULE11]
    else $error("status line driven high");
  a_mode_split: assert property (thermal_mode_q |-> !ov_act && act[4:1] == 4'h0) // see [RULE9]
    else $error("bus faults in thermal mode");
  a_apb_err: assert property (psel_i && penable_i |-> pslverr_o == !mapped)
    else $error("unmapped access not flagged");

endmodule : smq_monitor

/* File: logic/smq_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants of the system monitor fault qualifier
// ----------------------------------------------------------------------------
package smq_pkg;

  // clock and time base
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int TICK_DIV_W = 8;

  // qualification times in microseconds, counts in ticks
  localparam int UV_QUAL_TIME_US = 40000;
  localparam int OV_QUAL_TIME_US = 80;
  localparam int THERM_DELAY_TIME_US = 1000;
  localparam int UV_QUAL_TICKS = (UV_QUAL_TIME_US * 1000) / TICK_PERIOD_NS;
  localparam int OV_QUAL_TICKS = (OV_QUAL_TIME_US * 1000) / TICK_PERIOD_NS;
  localparam int THERM_DELAY_TICKS = (THERM_DELAY_TIME_US * 1000) / TICK_PERIOD_NS;
  localparam int QUAL_CNT_W = 24;

  // condition slots
  localparam int NUM_COND = 6;
  localparam int IDX_OV = 0;
  localparam int IDX_UV_FULL = 1;
  localparam int IDX_UV_85 = 2;
  localparam int IDX_UV_70 = 3;
  localparam int IDX_UV_55 = 4;
  localparam int IDX_THERM = 5;

  // system fault codes in status bits 0..2
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_OV = 3'h1;
  localparam logic [2:0] CODE_UV_FULL = 3'h2;
  localparam logic [2:0] CODE_UV_85 = 3'h3;
  localparam logic [2:0] CODE_UV_70 = 3'h4;
  localparam logic [2:0] CODE_UV_55 = 3'h5;
  localparam logic [2:0] CODE_THERM = 3'h6;

  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EVCNT = 8'h08;
  localparam int CTRL_REPORT_EN_BIT = 0;
  localparam logic CTRL_RESET_VAL = 1'b1;
  localparam int ST_CODE_LSB = 0;
  localparam int ST_MODE_BIT = 3;
  localparam int ST_INHIBIT_BIT = 4;
  localparam int ST_LINE_BIT = 5;
  localparam int ST_ACTIVE_LSB = 8;
  localparam int EVCNT_W = 16;

endpackage : smq_pkg

/* File: logic/smq_qual_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// one condition between the core and its qualifier
// ----------------------------------------------------------------------------
interface smq_qual_if;
  logic set_cond;
  logic clr_cond;
  logic active;
  logic changed;

  modport ctl (output set_cond, output clr_cond, input active, input changed);
  modport qual (input set_cond, input clr_cond, output active, output changed);
endinterface : smq_qual_if

/* File: logic/smq_qualifier.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// persistence timer: a condition must hold for LIMIT+1 ticks to flip state
// ----------------------------------------------------------------------------
module smq_qualifier #(
  parameter int LIMIT = 80
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  smq_qual_if.qual qif
);

  logic [smq_pkg::QUAL_CNT_W-1:0] cnt_q;
  logic active_q;
  logic changed_q;
  logic pending;

  if (LIMIT < 1 || LIMIT >= (2 ** smq_pkg::QUAL_CNT_W) - 1)
  begin : g_bad_limit
    $error("smq_qualifier: LIMIT out of range");
  end

  // the condition that would flip the state; the first tick may be partial,
  // so LIMIT+1 ticks guarantee at least LIMIT full tick periods
  assign pending = active_q ? qif.clr_cond : qif.set_cond;

  // any lapse restarts the timer without reporting (see [RULE15])
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !pending)
    begin
      cnt_q <= '0;
    end
    else if (tick_i)
    begin
      cnt_q <= (cnt_q == LIMIT[smq_pkg::QUAL_CNT_W-1:0]) ? '0 : cnt_q + 1'b1;
    end
  end

  // state flips and one change pulse when the timer completes
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      active_q <= 1'b0;
      changed_q <= 1'b0;
    end
    else
    begin
      changed_q <= pending && tick_i && (cnt_q == LIMIT[smq_pkg::QUAL_CNT_W-1:0]);
      if (pending && tick_i && (cnt_q == LIMIT[smq_pkg::QUAL_CNT_W-1:0]))
      begin
        active_q <= !active_q;
      end
    end
  end

  assign qif.active = active_q;
  assign qif.changed = changed_q;

  a_qual_restart: assert property (@(posedge mclk_i) disable iff (rst_i) // see [RULE15]
    !pending |=> (cnt_q == '0))
    else $error("qualifier timer not restarted after lapse");
  a_qual_cause: assert property (@(posedge mclk_i) disable iff (rst_i) // see [RULE3]
    $changed(active_q) |-> $past(pending) && $past(cnt_q) == LIMIT[smq_pkg::QUAL_CNT_W-1:0])
    else $error("qualifier flipped before its time");

endmodule : smq_qualifier

/* File: sim/smq_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// system controller side of the shared open-drain status wire
// ----------------------------------------------------------------------------
module smq_host_model (
  input wire logic dev_oe_i,
  input wire logic dev_out_i,
  input wire logic host_pull_i,
  output logic line_o
);
  // wired-and with an external pull-up: a released wire reads high, never the last value
  assign line_o = ~((dev_oe_i & ~dev_out_i) | host_pull_i);
endmodule : smq_host_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic mclk_i, rst_i, psel_i, penable_i, pwrite_i, mode_sense_i, ov_above, ov_release;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, err, thermal_below, low_req, high_req_n, low_drive, high_drive;
  logic [3:0] uv_below;
  logic pull_req, host_pull, line, line_o, line_oe, ev;
  logic [2:0] code;
  int num_errors = 0;
  int n_tests = 0;
  int ev_cnt = 0;

  smq_monitor #(.UV_TICKS(5), .OV_TICKS(3), .THERM_TICKS(4)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .mode_sense_i(mode_sense_i),
    .ov_above_cmp_i(ov_above), .ov_release_cmp_i(ov_release), .uv_below_cmp_i(uv_below),
    .thermal_below_cmp_i(thermal_below), .low_side_gate_request_i(low_req),
    .high_side_gate_request_n_i(high_req_n), .low_side_drive_o(low_drive),
    .high_side_drive_o(high_drive), .status_pull_req_i(pull_req), .status_line_i(line),
    .status_line_o(line_o), .status_line_oe_o(line_oe), .status_event_o(ev),
    .status_code_o(code));

  smq_host_model host (.dev_oe_i(line_oe), .dev_out_i(line_o), .host_pull_i(host_pull),
    .line_o(line));

  // ----------------------------------------------------------------------------
  // clock and event tally
  // ----------------------------------------------------------------------------
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // tally pulses so the event counter register can be judged independently
  always @(posedge mclk_i)
    if (ev === 1'b1 && rst_i === 1'b0) ev_cnt++;

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task final_report;
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; the wait for pready is bounded
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int i;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 50)
    begin
      num_errors++;
      final_report();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, addr, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask : rd_chk

  // waits for one status pulse, then judges the code it carries
  task wait_ev(input logic [2:0] exp);
    int i;
    for (i = 0; i < 4000; i++)
    begin
      @(posedge mclk_i);
      #1;
      if (ev === 1'b1) break;
    end
    if (i == 4000)
    begin
      num_errors++;
      final_report();
    end
    chk({29'h0, code}, {29'h0, exp});
  endtask : wait_ev

  task quiet(input int cycles);
    repeat (cycles)
    begin
      @(posedge mclk_i);
      #1;
      if (ev !== 1'b0) chk({31'h0, ev}, 32'h0);
    end
  endtask : quiet

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task t_regs;
    mode_sense_i <= 1'b1; // mode is already locked, so this must not show
    rd_chk(smq_pkg::REG_CTRL, 32'h1, 1'b0);
    rd_chk(smq_pkg::REG_STATUS, 32'h20, 1'b0);
    rd_chk(8'h0c, 32'h0, 1'b1);
    apb(1'b1, smq_pkg::REG_STATUS, 32'hffffffff);
    rd_chk(smq_pkg::REG_STATUS, 32'h20, 1'b0);
    apb(1'b1, smq_pkg::REG_CTRL, 32'h0);
    rd_chk(smq_pkg::REG_CTRL, 32'h0, 1'b0);
    apb(1'b1, smq_pkg::REG_CTRL, 32'h1);
  endtask : t_regs

  task t_ov;
    low_req <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 chk({31'h0, low_drive}, 32'h1);
    @(posedge mclk_i);
    ov_above <= 1'b1;
    ov_release <= 1'b0;
    wait_ev(smq_pkg::CODE_OV);
    chk({31'h0, low_drive}, 32'h0);
    @(posedge mclk_i);
    high_req_n <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 chk({31'h0, high_drive}, 32'h0);
    rd_chk(smq_pkg::REG_STATUS, 32'h131, 1'b0);
    @(posedge mclk_i);
    ov_above <= 1'b0; // inside the hysteresis band: no release yet
    quiet(1200);
    chk({29'h0, code}, {29'h0, smq_pkg::CODE_OV});
    @(posedge mclk_i);
    ov_release <= 1'b1;
    high_req_n <= 1'b1; // low-side request stays held across the release
    wait_ev(smq_pkg::CODE_NONE);
    repeat (2) @(posedge mclk_i);
    #1 chk({31'h0, low_drive}, 32'h0);
    @(posedge mclk_i);
    low_req <= 1'b0;
    @(posedge mclk_i);
    low_req <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 chk({31'h0, low_drive}, 32'h1);
    @(posedge mclk_i);
    low_req <= 1'b0;
  endtask : t_ov

  // overvoltage comparator stays low throughout, as with protection defeated
  task t_uv;
    logic [3:0] pats [7] = '{4'h1, 4'h3, 4'h7, 4'hf, 4'h7, 4'h3, 4'h0};
    logic [2:0] codes [7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h4, 3'h3, 3'h0};
    for (int i = 0; i < 7; i++)
    begin
      @(posedge mclk_i);
      uv_below <= pats[i];
      wait_ev(codes[i]);
      quiet(300);
    end
  endtask : t_uv

  task t_lapse;
    @(posedge mclk_i);
    uv_below <= 4'h1;
    repeat (800) @(posedge mclk_i);
    uv_below <= 4'h0;
    quiet(1600);
  endtask : t_lapse

  task t_line;
    @(posedge mclk_i);
    pull_req <= 1'b1;
    @(posedge mclk_i);
    #1 chk({30'h0, line_oe, line_o}, 32'h2);
    rd_chk(smq_pkg::REG_STATUS, 32'h0, 1'b0);
    pull_req <= 1'b0;
    host_pull <= 1'b1;
    rd_chk(smq_pkg::REG_STATUS, 32'h0, 1'b0);
    host_pull <= 1'b0;
    rd_chk(smq_pkg::REG_STATUS, 32'h20, 1'b0);
  endtask : t_line

  task t_thermal;
    rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_chk(smq_pkg::REG_STATUS, 32'h28, 1'b0);
    thermal_below <= 1'b1;
    wait_ev(smq_pkg::CODE_THERM);
  endtask : t_thermal

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    mode_sense_i = 1'b0;
    ov_above = 1'b0;
    ov_release = 1'b1;
    uv_below = 4'h0;
    thermal_below = 1'b0;
    low_req = 1'b0;
    high_req_n = 1'b1; // high-side request starts released; t_ov asserts it during the overvoltage to check the block
    pull_req = 1'b0;
    host_pull = 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs();
    t_ov();
    t_uv();
    t_lapse();
    t_line();
    // two overvoltage updates and seven undervoltage updates so far
    rd_chk(smq_pkg::REG_EVCNT, 32'h9, 1'b0);
    chk(ev_cnt, 32'h9);
    t_thermal(); // a fresh power-up follows the cleared overvoltage
    final_report();
  end
endmodule : tb
